/* File: ir_config_defs.svh */
// register offsets, field positions, reset values and timing counts for the infrared config bank
`ifndef IR_CONFIG_DEFS_SVH
`define IR_CONFIG_DEFS_SVH
`define IDX_RESERVED 8'h2a
`define IDX_BASE 8'h2b
`define IDX_DMA 8'h2c
`define IDX_TIMEOUT 8'h2d
`define IDX_SWSEL_A 8'h2e
`define IDX_SWSEL_B 8'h2f
`define RST_BASE 8'h00
`define RST_DMA 4'h0
`define RST_TIMEOUT 8'h03
`define RST_SWSEL 8'h00
`define RST_RESERVED 8'h00
`define ENG_BLOCK_TIMEOUT 3'h5
`define ENG_OFS_TIMEOUT 3'h1
`define ENG_BLOCK_SWSEL 3'h3
`define ENG_OFS_SWSEL_A 3'h5
`define ENG_OFS_SWSEL_B 3'h6
`define TIMEOUT_STEP_NS 100000
`define CLK_PERIOD_NS 4
`define TIMEOUT_STEP_CYCLES (`TIMEOUT_STEP_NS / `CLK_PERIOD_NS)
`endif

/* File: ir_config_pkg.sv */
// types shared by the infrared config bank
package ir_config_pkg;
    typedef enum logic [1:0] {
        turn_idle = 2'b00,
        turn_count = 2'b01,
        turn_done = 2'b11
    } turn_state_e;
endpackage : ir_config_pkg

/* File: ir_config_registers.sv */
// infrared engine configuration bank: base decode, dma routing, shadowed time-out and software selects
`timescale 1ns/1ps
`include "ir_config_defs.svh"
module ir_config_registers
    import ir_config_pkg::*;
#(
    parameter int unsigned STEP_CYCLES = `TIMEOUT_STEP_CYCLES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // configuration port
    input wire logic config_mode,
    input wire logic [7:0] config_index_register,
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata_q,
    // host io bus toward the engine window
    input wire logic chip_select_low,
    input wire logic [10:0] host_addr,
    // engine-side register access
    input wire logic [2:0] eng_block,
    input wire logic [2:0] eng_offset,
    input wire logic io_write_strobe,
    input wire logic [7:0] eng_wdata,
    output logic [7:0] eng_rdata_q,
    output logic eng_hit_q,
    output logic [2:0] eng_reg_offset_q,
    input wire logic eng_soft_reset,
    // engine dma request and turnaround
    input wire logic eng_dma_req,
    input wire logic turnaround_start,
    output logic turnaround_busy_q,
    output logic turnaround_expired_q,
    // transfer request pins, channels a..c
    output logic [2:0] transfer_request_out_q,
    output logic [2:0] transfer_request_out_oe_q,
    // software select levels into the engine
    output logic [7:0] swsel_a_q,
    output logic [7:0] swsel_b_q
);
    logic [7:0] base_q;
    logic [3:0] dma_q;
    logic [7:0] timeout_q;
    logic cfg_wr_ok;
    logic eng_wr_ok;
    logic decode_en;
    logic window_hit;
    logic base_cfg_we;
    logic dma_cfg_we;
    logic timeout_cfg_we;
    logic timeout_eng_we;
    logic swsel_a_cfg_we;
    logic swsel_a_eng_we;
    logic swsel_b_cfg_we;
    logic swsel_b_eng_we;
    logic timeout_view;
    logic swsel_a_view;
    logic swsel_b_view;
    logic [7:0] cfg_rdata_d;
    logic [7:0] eng_rdata_d;
    logic [2:0] grant_d;
    logic step_tick;
    logic last_step;
    turn_state_e turn_q;
    turn_state_e turn_d;
    logic [7:0] steps_q;
    logic [$clog2(STEP_CYCLES+1)-1:0] tick_q;

    // engine-side block and offset match
    function automatic logic eng_sel(input logic [2:0] blk, input logic [2:0] ofs, input logic [2:0] b,
                                     input logic [2:0] o);
        eng_sel = (blk == b) && (ofs == o);
    endfunction : eng_sel

    // one channel owned by the engine; codes above 3 own nothing
    function automatic logic dma_grant(input logic [3:0] code, input logic [1:0] ch);
        dma_grant = (code == ({2'b00, ch} + 4'h1));
    endfunction : dma_grant

    // window match on address bits 10..3, only with chip select low
    function automatic logic in_window(input logic cs_n, input logic [10:0] addr, input logic [7:0] base);
        in_window = !cs_n && (addr[10:3] == base);
    endfunction : in_window

    // config access only in config state, index picks the register
    assign cfg_wr_ok = cfg_wr && config_mode;
    assign eng_wr_ok = io_write_strobe && !eng_soft_reset;
    assign base_cfg_we = cfg_wr_ok && (config_index_register == `IDX_BASE);
    assign dma_cfg_we = cfg_wr_ok && (config_index_register == `IDX_DMA);
    assign timeout_cfg_we = cfg_wr_ok && (config_index_register == `IDX_TIMEOUT);
    assign swsel_a_cfg_we = cfg_wr_ok && (config_index_register == `IDX_SWSEL_A);
    assign swsel_b_cfg_we = cfg_wr_ok && (config_index_register == `IDX_SWSEL_B);

    // engine views of the shared storage
    assign timeout_view = eng_sel(eng_block, eng_offset, `ENG_BLOCK_TIMEOUT, `ENG_OFS_TIMEOUT);
    assign swsel_a_view = eng_sel(eng_block, eng_offset, `ENG_BLOCK_SWSEL, `ENG_OFS_SWSEL_A);
    assign swsel_b_view = eng_sel(eng_block, eng_offset, `ENG_BLOCK_SWSEL, `ENG_OFS_SWSEL_B);
    // soft reset must not gate the time-out path, it is a legacy shadow
    assign timeout_eng_we = io_write_strobe && timeout_view;
    assign swsel_a_eng_we = eng_wr_ok && swsel_a_view;
    assign swsel_b_eng_we = eng_wr_ok && swsel_b_view;

    assign decode_en = |base_q[7:5];
    assign window_hit = in_window(chip_select_low, host_addr, base_q);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            base_q <= `RST_BASE;
        end else if (base_cfg_we) begin
            base_q <= cfg_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dma_q <= `RST_DMA;
        end else if (dma_cfg_we) begin
            dma_q <= cfg_wdata[3:0];
        end
    end

    // one storage for both views; config write wins a same-cycle clash
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            timeout_q <= `RST_TIMEOUT;
        end else if (timeout_cfg_we) begin
            timeout_q <= cfg_wdata;
        end else if (timeout_eng_we) begin
            timeout_q <= eng_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            swsel_a_q <= `RST_SWSEL;
        end else if (swsel_a_cfg_we) begin
            swsel_a_q <= cfg_wdata;
        end else if (swsel_a_eng_we) begin
            swsel_a_q <= eng_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            swsel_b_q <= `RST_SWSEL;
        end else if (swsel_b_cfg_we) begin
            swsel_b_q <= cfg_wdata;
        end else if (swsel_b_eng_we) begin
            swsel_b_q <= eng_wdata;
        end
    end

    // config read mux; unknown and reserved indices read zero
    always_comb begin
        cfg_rdata_d = 8'h00;
        if (config_mode) begin
            unique case (config_index_register)
                `IDX_RESERVED: cfg_rdata_d = `RST_RESERVED;
                `IDX_BASE: cfg_rdata_d = base_q;
                `IDX_DMA: cfg_rdata_d = {4'h0, dma_q};
                `IDX_TIMEOUT: cfg_rdata_d = timeout_q;
                `IDX_SWSEL_A: cfg_rdata_d = swsel_a_q;
                `IDX_SWSEL_B: cfg_rdata_d = swsel_b_q;
                default: cfg_rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cfg_rdata_q <= 8'h00;
        end else begin
            cfg_rdata_q <= cfg_rdata_d;
        end
    end

    // engine-side read view of the shared registers
    always_comb begin
        eng_rdata_d = 8'h00;
        if (timeout_view) begin
            eng_rdata_d = timeout_q;
        end else if (swsel_a_view) begin
            eng_rdata_d = swsel_a_q;
        end else if (swsel_b_view) begin
            eng_rdata_d = swsel_b_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            eng_rdata_q <= 8'h00;
        end else begin
            eng_rdata_q <= eng_rdata_d;
        end
    end

    // window decode, registered so outputs come from flops
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            eng_hit_q <= 1'b0;
        end else begin
            eng_hit_q <= decode_en && window_hit;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            eng_reg_offset_q <= 3'h0;
        end else begin
            eng_reg_offset_q <= host_addr[2:0];
        end
    end

    // request routing; unselected pins released
    always_comb begin
        grant_d = 3'h0;
        for (int i = 0; i < 3; i++) begin
            grant_d[i] = dma_grant(dma_q, 2'(i));
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            transfer_request_out_oe_q <= 3'h0;
        end else begin
            transfer_request_out_oe_q <= grant_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            transfer_request_out_q <= 3'h0;
        end else begin
            transfer_request_out_q <= grant_d & {3{eng_dma_req}};
        end
    end

    // turnaround timer: value times one step; zero expires at once
    assign step_tick = (tick_q == ($bits(tick_q))'(STEP_CYCLES - 1));
    assign last_step = (steps_q == 8'h01);

    always_comb begin
        turn_d = turn_q;
        unique case (turn_q)
            turn_idle: begin
                if (turnaround_start) begin
                    turn_d = (timeout_q == 8'h00) ? turn_done : turn_count;
                end
            end
            turn_count: begin
                if (step_tick && last_step) begin
                    turn_d = turn_done;
                end
            end
            turn_done: begin
                turn_d = turn_idle;
            end
            default: begin
                turn_d = turn_idle;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            turn_q <= turn_idle;
        end else begin
            turn_q <= turn_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            steps_q <= 8'h00;
        end else if (turn_q == turn_idle && turnaround_start) begin
            steps_q <= timeout_q;
        end else if (turn_q == turn_count && step_tick) begin
            steps_q <= steps_q - 8'h01;
        end
    end

    // step divider gives the one-cycle enable, held at zero outside a count
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tick_q <= '0;
        end else if (turn_q != turn_count || step_tick) begin
            tick_q <= '0;
        end else begin
            tick_q <= tick_q + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            turnaround_busy_q <= 1'b0;
        end else begin
            turnaround_busy_q <= (turn_q == turn_count);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            turnaround_expired_q <= 1'b0;
        end else begin
            turnaround_expired_q <= (turn_q == turn_done);
        end
    end
endmodule : ir_config_registers

/* File: ir_config_registers_asserts.sv */
// assertions on the infrared config bank ports
`timescale 1ns/1ps
module ir_config_registers_chk (
    // clock, reset, config port
    input logic core_clk,
    input logic rst_n,
    input logic config_mode,
    input logic [7:0] config_index_register,
    input logic cfg_wr,
    input logic [7:0] cfg_wdata,
    input logic [7:0] cfg_rdata_q,
    // engine side and pins
    input logic chip_select_low,
    input logic eng_hit_q,
    input logic [2:0] eng_block,
    input logic [2:0] eng_offset,
    input logic io_write_strobe,
    input logic [7:0] eng_wdata,
    input logic [7:0] eng_rdata_q,
    input logic eng_soft_reset,
    input logic [2:0] transfer_request_out_oe_q,
    input logic [7:0] swsel_a_q,
    input logic [7:0] swsel_b_q
);
    wire logic cw = config_mode && cfg_wr;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_to_wr; cw && config_index_register == 8'h2d; endsequence
    sequence s_to_view; eng_block == 3'h5 && eng_offset == 3'h1 && !cfg_wr && !io_write_strobe; endsequence
    property p_to_shadow; s_to_wr ##1 s_to_view |=> eng_rdata_q == $past(cfg_wdata, 2); endproperty
    a_to_shadow: assert property (p_to_shadow) else $error("time-out views differ");
    property p_oe_onehot; $onehot0(transfer_request_out_oe_q); endproperty
    a_oe_onehot: assert property (p_oe_onehot) else $error("two request pins driven");
    property p_hit_cs; eng_hit_q |-> !$past(chip_select_low); endproperty
    a_hit_cs: assert property (p_hit_cs) else $error("hit without chip select");
    property p_rsvd; config_mode && config_index_register == 8'h2a |=> cfg_rdata_q == 8'h00; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved slot not zero");
    property p_dma_hi; config_mode && config_index_register == 8'h2c |=> cfg_rdata_q[7:4] == 4'h0; endproperty
    a_dma_hi: assert property (p_dma_hi) else $error("dma upper nibble set");
    property p_swa; io_write_strobe && !cw && !eng_soft_reset && eng_block == 3'h3 && eng_offset == 3'h5
        |=> swsel_a_q == $past(eng_wdata); endproperty
    a_swa: assert property (p_swa) else $error("select a missed engine write");
    property p_swb; cw && config_index_register == 8'h2f |=> swsel_b_q == $past(cfg_wdata); endproperty
    a_swb: assert property (p_swb) else $error("select b missed config write");
    property p_soft; eng_soft_reset && !cw |=> $stable(swsel_a_q) && $stable(swsel_b_q);
    endproperty
    a_soft: assert property (p_soft) else $error("soft reset changed selects");
endmodule : ir_config_registers_chk
bind ir_config_registers ir_config_registers_chk chk_i (.*);

/* File: host_bfm.sv */
// host model: configuration cycles and engine window address
`timescale 1ns/1ps
module host_bfm (
    // clock and read back
    input logic core_clk,
    input logic [7:0] cfg_rdata_q,
    // config and io drive
    output logic config_mode,
    output logic [7:0] config_index_register,
    output logic cfg_wr,
    output logic [7:0] cfg_wdata,
    output logic chip_select_low,
    output logic [10:0] host_addr
);
    initial begin
        {config_mode, cfg_wr, config_index_register, cfg_wdata} = 18'h0;
        chip_select_low = 1'b1;
        host_addr = 11'h0;
    end
    // index and mode go up with the strobe, never after it
    task automatic cfg_write(input logic [7:0] i, input logic [7:0] d);
        @(posedge core_clk);
        config_mode <= 1'b1;
        config_index_register <= i;
        cfg_wdata <= d;
        cfg_wr <= 1'b1;
        @(posedge core_clk);
        cfg_wr <= 1'b0;
    endtask : cfg_write
    task automatic cfg_read(input logic [7:0] i, output logic [7:0] d);
        @(posedge core_clk);
        config_mode <= 1'b1;
        config_index_register <= i;
        @(posedge core_clk);
        #1 d = cfg_rdata_q;
    endtask : cfg_read
    task automatic io_addr(input logic cs_n, input logic [10:0] a);
        @(posedge core_clk);
        chip_select_low <= cs_n;
        host_addr <= a;
    endtask : io_addr
endmodule : host_bfm

/* File: ir_config_registers_tb_top.sv */
// self-checking bench for the infrared config bank
`timescale 1ns/1ps
module ir_config_registers_tb_top;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic config_mode, cfg_wr, chip_select_low, eng_hit_q, io_write_strobe, eng_soft_reset;
    logic eng_dma_req, turnaround_start, turnaround_busy_q, turnaround_expired_q;
    logic [7:0] config_index_register, cfg_wdata, cfg_rdata_q, eng_wdata, eng_rdata_q, swsel_a_q, swsel_b_q, rd;
    logic [10:0] host_addr;
    logic [2:0] eng_block, eng_offset, eng_reg_offset_q, transfer_request_out_q, transfer_request_out_oe_q;
    int fails = 0;
    int total_checks = 0;
    int n, e;
    always #2 core_clk = ~core_clk;
    // short time-out step keeps the timer run brief
    ir_config_registers #(.STEP_CYCLES(4)) ir_config_registers_i (.*);
    host_bfm host_bfm_i (.*);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic eng_wr(input logic [2:0] b, input logic [2:0] o, input logic [7:0] d);
        @(posedge core_clk);
        {eng_block, eng_offset, eng_wdata, io_write_strobe} <= {b, o, d, 1'b1};
        @(posedge core_clk);
        io_write_strobe <= 1'b0;
    endtask : eng_wr
    task automatic eng_rd(input logic [2:0] b, input logic [2:0] o, output logic [7:0] d);
        @(posedge core_clk);
        {eng_block, eng_offset} <= {b, o};
        @(posedge core_clk);
        #1 d = eng_rdata_q;
    endtask : eng_rd
    task automatic dec(input logic [7:0] b, input logic cs_n, input logic [10:0] a, input logic hit);
        host_bfm_i.cfg_write(8'h2b, b);
        host_bfm_i.io_addr(cs_n, a);
        repeat (2) @(posedge core_clk);
        #1 chk({7'h0, eng_hit_q}, {7'h0, hit});
        if (hit) chk({5'h0, eng_reg_offset_q}, {5'h0, a[2:0]});
    endtask : dec
    task automatic test_done;
        if (fails == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done
    initial begin
        {io_write_strobe, eng_soft_reset, eng_dma_req, turnaround_start, eng_wdata} = 12'h0;
        {eng_block, eng_offset} = {3'h5, 3'h1};
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            host_bfm_i.cfg_read(8'h2a + i[7:0], rd);
            chk(rd, (i == 3) ? 8'h03 : 8'h00);
        end
        host_bfm_i.cfg_write(8'h2c, 8'hff);
        host_bfm_i.cfg_read(8'h2c, rd);
        chk(rd, 8'h0f);
        chk({5'h0, transfer_request_out_oe_q}, 8'h00);
        eng_dma_req <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            host_bfm_i.cfg_write(8'h2c, c[7:0]);
            repeat (2) @(posedge core_clk);
            #1 rd = 8'((c == 0) ? 0 : 1 << (c - 1));
            chk({5'h0, transfer_request_out_oe_q}, rd);
            chk({5'h0, transfer_request_out_q & transfer_request_out_oe_q}, rd);
        end
        dec(8'h20, 1'b0, 11'h105, 1'b1);
        dec(8'h20, 1'b1, 11'h105, 1'b0);
        dec(8'h20, 1'b0, 11'h10d, 1'b0);
        dec(8'h1f, 1'b0, 11'h0fa, 1'b0);
        dec(8'hff, 1'b0, 11'h7ff, 1'b1);
        {eng_block, eng_offset} <= {3'h5, 3'h1};
        host_bfm_i.cfg_write(8'h2d, 8'h02);
        eng_rd(3'h5, 3'h1, rd);
        chk(rd, 8'h02);
        @(posedge core_clk);
        turnaround_start <= 1'b1;
        @(posedge core_clk);
        turnaround_start <= 1'b0;
        n = 0;
        e = 0;
        repeat (40) begin
            #1 n += int'(turnaround_busy_q === 1'b1);
            e += int'(turnaround_expired_q === 1'b1);
            @(posedge core_clk);
        end
        chk(n[7:0], 8'h08);
        chk(e[7:0], 8'h01);
        eng_wr(3'h5, 3'h1, 8'h01);
        host_bfm_i.cfg_read(8'h2d, rd);
        chk(rd, 8'h01);
        eng_wr(3'h3, 3'h5, 8'ha5);
        host_bfm_i.cfg_read(8'h2e, rd);
        chk(rd, 8'ha5);
        host_bfm_i.cfg_write(8'h2f, 8'h5a);
        eng_rd(3'h3, 3'h6, rd);
        chk(rd, 8'h5a);
        @(posedge core_clk);
        eng_soft_reset <= 1'b1;
        eng_wr(3'h3, 3'h5, 8'h00);
        eng_soft_reset <= 1'b0;
        host_bfm_i.cfg_read(8'h2d, rd);
        chk(rd, 8'h01);
        chk(swsel_a_q, 8'ha5);
        chk(swsel_b_q, 8'h5a);
        host_bfm_i.cfg_write(8'h2a, 8'hff);
        host_bfm_i.cfg_read(8'h2a, rd);
        chk(rd, 8'h00);
        test_done;
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        fails++;
        test_done;
    end
endmodule : ir_config_registers_tb_top
